// ---- audio_power_manager.sv ----
`timescale 1ns/1ns
`include "audio_power_manager_defines.svh"

module audio_power_manager
  import audio_power_manager_pkg::*;
#(
  parameter int TICK_CYCLES = `APM_TICK_CYCLES,
  parameter logic [11:0] AUDIO_BASE = `APM_AUDIO_BASE,
  parameter logic [11:0] MUSIC_BASE = `APM_MUSIC_BASE
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic softReset,
  input wire logic [11:0] ioAddr,
  input wire logic ioRead,
  input wire logic ioWrite,
  input wire logic [7:0] writeData,
  input wire logic otherDeviceAccess,
  input wire logic serialActivity,
  input wire logic midiSerialMode,
  input wire logic useCrystal,
  output logic [7:0] readData,
  output logic powerDownIrq,
  output logic [1:0] powerState,
  output logic oscillatorEnable,
  output logic analogEnable,
  output logic audioEnable,
  output logic synthMute,
  output logic processorHold,
  output logic general_output_a,
  output logic general_output_b
);

  localparam int TICK_W = $clog2(TICK_CYCLES + 1);

  power_state_t state;
  indirect_state_t indirect;
  logic [7:0] control;
  logic [7:0] outputPowerDown;
  logic [3:0] activity;
  logic [TICK_W-1:0] tickCount;
  logic [2:0] restoreCount;
  logic restorePending;
  logic invertA;
  logic invertB;

  logic access;
  logic statusHit;
  logic controlHit;
  logic audioHit;
  logic audioLowHit;
  logic musicHit;
  logic anyChipHit;
  logic wake;
  logic restoreDone;
  logic tick;
  logic requestRise;
  logic [3:0] next_activity;
  logic [7:0] statusValue;

  assign access = ioRead | ioWrite;
  assign statusHit = ioAddr == `APM_STATUS_PORT;
  assign controlHit = ioAddr == `APM_CONTROL_PORT;
  assign audioHit = ioAddr[11:4] == AUDIO_BASE[11:4];
  assign audioLowHit = audioHit && (ioAddr[3:0] == 4'h4 || ioAddr[3:0] == 4'h5);
  assign musicHit = ioAddr[11:2] == MUSIC_BASE[11:2];
  assign anyChipHit = audioHit | musicHit | otherDeviceAccess;

  // serial traffic is deliberately not a wake source: data is lost
  always_comb
  begin
    wake = 1'b0;
    unique case (state)
      POWER_ACTIVE:
        wake = 1'b0;
      POWER_PARTIAL:
        wake = access && (musicHit || (audioHit && ioAddr[3:2] != 2'b01));
      POWER_FULL:
        // any chip port but status and control, and none while useCrystal is set
        wake = access && !useCrystal && anyChipHit && !statusHit && !controlHit;
    endcase
  end

  assign requestRise = ioWrite && controlHit && indirect != INDIRECT_WRITE
    && writeData[`APM_CTL_PD_REQUEST] && !control[`APM_CTL_PD_REQUEST]
    && writeData != `APM_CMD_WRITE_OPD && writeData != `APM_CMD_READ_OPD;

  always_ff @(posedge clock)
  begin
    if (!rst_n || softReset)
    begin
      powerDownIrq <= 1'b0;
    end
    else
    begin
      powerDownIrq <= requestRise;
    end
  end

  // power state; a held processor cannot service the request
  always_ff @(posedge clock)
  begin
    if (!rst_n || softReset)
    begin
      state <= POWER_ACTIVE;
    end
    else if (wake)
    begin
      state <= POWER_ACTIVE;
    end
    else if (requestRise && !processorHold && state == POWER_ACTIVE)
    begin
      state <= writeData[`APM_CTL_PARTIAL] ? POWER_PARTIAL : POWER_FULL;
    end
  end

  assign powerState = state;
  // oscillator only stops in full power-down
  assign oscillatorEnable = state != POWER_FULL;
  assign analogEnable = state != POWER_FULL;
  // audio and synthesis disabled when down
  assign audioEnable = state == POWER_ACTIVE;
  assign synthMute = state != POWER_ACTIVE;

  // indirect command tracking on the control port
  always_ff @(posedge clock)
  begin
    if (!rst_n || softReset)
    begin
      indirect <= INDIRECT_IDLE;
    end
    else if (controlHit && ioWrite)
    begin
      if (indirect == INDIRECT_WRITE)
      begin
        indirect <= INDIRECT_IDLE;
      end
      else if (writeData == `APM_CMD_WRITE_OPD)
      begin
        indirect <= INDIRECT_WRITE;
      end
      else if (writeData == `APM_CMD_READ_OPD)
      begin
        indirect <= INDIRECT_READ;
      end
      else
      begin
        indirect <= INDIRECT_IDLE;
      end
    end
    else if (controlHit && ioRead)
    begin
      indirect <= INDIRECT_IDLE;
    end
  end

  // control port levels; commands leave the bits alone
  always_ff @(posedge clock)
  begin
    if (!rst_n || softReset)
    begin
      control <= 8'h00;
    end
    else if (controlHit && ioWrite && indirect != INDIRECT_WRITE
      && writeData != `APM_CMD_WRITE_OPD && writeData != `APM_CMD_READ_OPD)
    begin
      control <= writeData;
    end
  end

  // soft reset does not touch it
  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      outputPowerDown <= `APM_OPD_RESET;
    end
    else if (controlHit && ioWrite && indirect == INDIRECT_WRITE)
    begin
      outputPowerDown <= writeData & `APM_OPD_USED_MASK;
    end
  end

  // processor hold: set by any reset, host clears it
  always_ff @(posedge clock)
  begin
    if (!rst_n || softReset)
    begin
      processorHold <= 1'b1;
    end
    else if (statusHit && ioWrite)
    begin
      processorHold <= writeData[`APM_STS_HOLD];
    end
  end

  // sticky activity flags, cleared by status read; set wins
  always_comb
  begin
    next_activity = activity;
    if (statusHit && ioRead)
    begin
      next_activity = 4'h0;
    end
    if (serialActivity)
    begin
      next_activity[0] = 1'b1;
    end
    if (access && ((audioHit && !audioLowHit && ioAddr[3:1] != 3'b011) || musicHit))
    begin
      next_activity[1] = 1'b1;
    end
    if (access && audioLowHit)
    begin
      next_activity[2] = 1'b1;
    end
    if (access && otherDeviceAccess)
    begin
      next_activity[3] = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n || softReset)
    begin
      activity <= 4'h0;
    end
    else
    begin
      activity <= next_activity;
    end
  end

  always_comb
  begin
    statusValue = 8'h00;
    statusValue[`APM_STS_HOLD] = processorHold;
    statusValue[`APM_STS_MIDI_MODE] = midiSerialMode;
    statusValue[`APM_STS_POWERED] = state == POWER_ACTIVE;
    statusValue[`APM_STS_ACT_OTHER:`APM_STS_ACT_SERIAL] =
      {activity[3], activity[2], activity[1], activity[0]};
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      readData <= 8'h00;
    end
    else if (ioRead && statusHit)
    begin
      readData <= statusValue;
    end
    else if (ioRead && controlHit)
    begin
      readData <= indirect == INDIRECT_READ ? outputPowerDown : control;
    end
    else if (ioRead)
    begin
      readData <= 8'h00;
    end
  end

  // 16 Hz tick divider, restarted on wake so the first step is whole
  always_ff @(posedge clock)
  begin
    if (!rst_n || softReset || wake || tick)
    begin
      tickCount <= '0;
    end
    else
    begin
      tickCount <= tickCount + TICK_W'(1);
    end
  end

  assign tick = tickCount == TICK_W'(TICK_CYCLES - 1);
  assign restoreDone = restoreCount == outputPowerDown[2:0];

  // counts from zero until equal to delay select
  always_ff @(posedge clock)
  begin
    if (!rst_n || softReset)
    begin
      restorePending <= 1'b0;
      restoreCount <= 3'h0;
    end
    else if (wake)
    begin
      restorePending <= state == POWER_FULL;
      restoreCount <= 3'h0;
    end
    else if (restorePending && restoreDone)
    begin
      restorePending <= 1'b0;
    end
    else if (restorePending && tick)
    begin
      restoreCount <= restoreCount + 3'h1;
    end
  end

  // timed restore holds inversion until the delay runs out
  always_comb
  begin
    invertA = 1'b0;
    invertB = 1'b0;
    if (state == POWER_FULL)
    begin
      invertA = outputPowerDown[`APM_OPD_INVERT_A];
      invertB = outputPowerDown[`APM_OPD_INVERT_B];
    end
    else if (state == POWER_ACTIVE && restorePending)
    begin
      invertA = outputPowerDown[`APM_OPD_INVERT_A] && outputPowerDown[`APM_OPD_TIMED_A];
      invertB = outputPowerDown[`APM_OPD_INVERT_B] && outputPowerDown[`APM_OPD_TIMED_B];
    end
  end

  always_ff @(posedge clock)
  begin
    if (!rst_n)
    begin
      general_output_a <= 1'b0;
      general_output_b <= 1'b0;
    end
    else
    begin
      general_output_a <= control[`APM_CTL_LEVEL_A] ^ invertA;
      general_output_b <= control[`APM_CTL_LEVEL_B] ^ invertB;
    end
  end

endmodule

// ---- audio_power_manager_defines.svh ----
`ifndef AUDIO_POWER_MANAGER_DEFINES_SVH
`define AUDIO_POWER_MANAGER_DEFINES_SVH

// host port addresses
`define APM_STATUS_PORT 12'h226
`define APM_CONTROL_PORT 12'h227
`define APM_AUDIO_BASE 12'h220
`define APM_MUSIC_BASE 12'h388
// indirect commands on the control port
`define APM_CMD_WRITE_OPD 8'hCF
`define APM_CMD_READ_OPD 8'hCE
// control port fields
`define APM_CTL_LEVEL_A 0
`define APM_CTL_LEVEL_B 1
`define APM_CTL_PD_REQUEST 2
`define APM_CTL_PARTIAL 3
// status port fields
`define APM_STS_HOLD 0
`define APM_STS_MIDI_MODE 2
`define APM_STS_POWERED 3
`define APM_STS_ACT_SERIAL 4
`define APM_STS_ACT_AUDIO 5
`define APM_STS_ACT_LOW 6
`define APM_STS_ACT_OTHER 7
// output power-down control fields
`define APM_OPD_RESET 8'h00
`define APM_OPD_USED_MASK 8'hF7
`define APM_OPD_INVERT_A 4
`define APM_OPD_TIMED_A 5
`define APM_OPD_INVERT_B 6
`define APM_OPD_TIMED_B 7
// timing
`define APM_CLOCK_HZ 100000000
`define APM_RESTORE_TICK_HZ 16
`define APM_TICK_CYCLES (`APM_CLOCK_HZ / `APM_RESTORE_TICK_HZ)

`endif

// ---- audio_power_manager_pkg.sv ----
package audio_power_manager_pkg;

  // gray coded along active -> partial -> full
  typedef enum logic [1:0] {
    POWER_ACTIVE = 2'b00,
    POWER_PARTIAL = 2'b01,
    POWER_FULL = 2'b11
  } power_state_t;

  typedef enum logic [1:0] {
    INDIRECT_IDLE = 2'b00,
    INDIRECT_WRITE = 2'b01,
    INDIRECT_READ = 2'b11
  } indirect_state_t;

endpackage

// ---- audio_power_manager_properties.sv ----
`timescale 1ns/1ns
module audio_power_manager_properties
  import audio_power_manager_pkg::*;
#(
  parameter logic [11:0] AUDIO_BASE = 12'h220
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic softReset,
  input wire logic [11:0] ioAddr,
  input wire logic ioRead,
  input wire logic ioWrite,
  input wire logic [7:0] writeData,
  input wire logic useCrystal,
  input wire logic [7:0] readData,
  input wire logic powerDownIrq,
  input wire logic [1:0] powerState,
  input wire logic oscillatorEnable,
  input wire logic analogEnable,
  input wire logic audioEnable,
  input wire logic synthMute
);
  logic acc;
  logic down;
  assign acc = ioRead || ioWrite;
  assign down = powerState != POWER_ACTIVE;
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  irq_cause_a: assert property (powerDownIrq |-> $past(ioWrite) &&
    $past(ioAddr) == 12'h227 && $past(writeData[2])) else $error("irq without request");
  pd_entry_a: assert property (down && !$past(down) |-> powerDownIrq &&
    powerState == ($past(writeData[3]) ? POWER_PARTIAL : POWER_FULL)) else $error("bad entry");
  partial_power_a: assert property (powerState == POWER_PARTIAL |->
    oscillatorEnable && analogEnable && !audioEnable && synthMute) else $error("partial");
  full_power_a: assert property (powerState == POWER_FULL |->
    !oscillatorEnable && !analogEnable && synthMute) else $error("full");
  wake_full_a: assert property (powerState == POWER_FULL && acc && !useCrystal &&
    ioAddr == AUDIO_BASE |=> powerState == POWER_ACTIVE) else $error("no wake");
  port_no_wake_a: assert property (down && acc && !softReset &&
    ioAddr inside {12'h226, 12'h227} |=> $stable(powerState)) else $error("woke on port");
  status_power_a: assert property (ioRead && ioAddr == 12'h226 && !softReset |=>
    readData[3] == ($past(powerState) == POWER_ACTIVE)) else $error("status bit 3");
  crystal_hold_a: assert property (powerState == POWER_FULL && useCrystal && !softReset
    |=> powerState == POWER_FULL) else $error("crystal wake");
endmodule
bind audio_power_manager audio_power_manager_properties #(.AUDIO_BASE(AUDIO_BASE)) props (
  .clock(clock), .rst_n(rst_n), .softReset(softReset), .ioAddr(ioAddr), .ioRead(ioRead),
  .ioWrite(ioWrite), .writeData(writeData), .useCrystal(useCrystal), .readData(readData),
  .powerDownIrq(powerDownIrq), .powerState(powerState), .oscillatorEnable(oscillatorEnable),
  .analogEnable(analogEnable), .audioEnable(audioEnable), .synthMute(synthMute)
);

// ---- host_port_model.sv ----
`timescale 1ns/1ns
module host_port_model
(
  input wire logic clock,
  output logic [11:0] ioAddr,
  output logic ioRead,
  output logic ioWrite,
  output logic [7:0] writeData
);
  initial
  begin
    ioAddr = 12'h000;
    {ioRead, ioWrite, writeData} = 10'h000;
  end
  // released bus shows the inverse so stale values never pass
  task automatic access(input logic [11:0] a, input logic [7:0] d, input logic rd);
    @(posedge clock);
    #1;
    {ioAddr, writeData, ioRead, ioWrite} = {a, d, rd, !rd};
    @(posedge clock);
    #1;
    {ioAddr, writeData, ioRead, ioWrite} = {~a, ~d, 2'b00};
  endtask
  task automatic request_pd(input logic [7:0] c);
    access(12'h227, c, 1'b0);
    access(12'h227, c | 8'h04, 1'b0);
    access(12'h227, c, 1'b0);
  endtask
endmodule

// ---- audio_power_manager_tb.sv ----
`timescale 1ns/1ns
module audio_power_manager_tb
  import audio_power_manager_pkg::*;
();
  localparam int TICK = 8;
  logic clock, rst_n, softReset, otherDeviceAccess, serialActivity, midiSerialMode, useCrystal;
  logic ioRead, ioWrite, powerDownIrq, oscillatorEnable, analogEnable, audioEnable, synthMute;
  logic processorHold, general_output_a, general_output_b;
  logic [11:0] ioAddr;
  logic [7:0] writeData, readData;
  logic [1:0] powerState;
  logic [31:0] seed = 32'h40C8;
  int nFail = 0, totalChecks = 0, cycles = 0, irqCount = 0, expIrq = 0, ctl = 0, opd = 0;
  int opdQ[$] = '{8'h5F, 8'hF2, 8'h31};
  host_port_model host (.clock(clock), .ioAddr(ioAddr), .ioRead(ioRead), .ioWrite(ioWrite),
    .writeData(writeData));
  audio_power_manager #(.TICK_CYCLES(TICK)) dut (.clock(clock), .rst_n(rst_n),
    .softReset(softReset), .ioAddr(ioAddr), .ioRead(ioRead), .ioWrite(ioWrite),
    .writeData(writeData), .otherDeviceAccess(otherDeviceAccess),
    .serialActivity(serialActivity), .midiSerialMode(midiSerialMode), .useCrystal(useCrystal),
    .readData(readData), .powerDownIrq(powerDownIrq), .powerState(powerState),
    .oscillatorEnable(oscillatorEnable), .analogEnable(analogEnable),
    .audioEnable(audioEnable), .synthMute(synthMute), .processorHold(processorHold),
    .general_output_a(general_output_a), .general_output_b(general_output_b));
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cycles++;
    if (powerDownIrq === 1'b1)
      irqCount++;
    if (cycles == 5000)
    begin
      nFail++;
      finishTest();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic finishTest();
    $display("checks %0d mismatches %0d", totalChecks, nFail);
    if (nFail == 0 && totalChecks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    totalChecks++;
    if (got !== exp)
    begin
      nFail++;
      $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    host.access(a, d, 1'b0);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    host.access(a, 8'h00, 1'b1);
    check(readData, exp);
  endtask
  task automatic st(input logic [1:0] s);
    check({6'h00, powerState}, {6'h00, s});
  endtask
  task automatic pd(input int partial, input logic [1:0] s);
    host.request_pd(8'(ctl + partial * 8));
    expIrq++;
    check(8'(irqCount), 8'(expIrq));
    st(s);
  endtask
  task automatic chkGpo(input logic [1:0] m);
    check({6'h00, general_output_b, general_output_a},
      {6'h00, ctl[1] ^ (m[1] & opd[6]), ctl[0] ^ (m[0] & opd[4])});
  endtask
  initial
  begin
    {softReset, otherDeviceAccess, serialActivity, midiSerialMode, useCrystal} = 5'h00;
    rst_n = 1'b0;
    cyc(16);
    rst_n = 1'b1;
    check({3'h0, processorHold, powerState, general_output_b, general_output_a}, 8'h10);
    wr(12'h227, 8'hCE);
    rd(12'h227, 8'h00);
    rd(12'h226, 8'h09);
    pd(1, POWER_ACTIVE);
    wr(12'h226, 8'h00);
    midiSerialMode = 1'b1;
    wr(12'h224, 8'h00);
    wr(12'h388, 8'h00);
    otherDeviceAccess = 1'b1;
    wr(12'h300, 8'h00);
    otherDeviceAccess = 1'b0;
    serialActivity = 1'b1;
    cyc(1);
    serialActivity = 1'b0;
    rd(12'h226, 8'hFC);
    rd(12'h226, 8'h0C);
    midiSerialMode = 1'b0;
    $display("test status done");
    foreach (opdQ[i])
    begin
      seed = xs(seed);
      ctl = int'(seed[1:0]);
      opd = opdQ[i];
      wr(12'h227, 8'(ctl));
      wr(12'h227, 8'hCF);
      wr(12'h227, 8'(opd));
      wr(12'h227, 8'hCE);
      rd(12'h227, 8'(opd & 8'hF7));
      chkGpo(2'b00);
      pd(0, POWER_FULL);
      cyc(1);
      chkGpo(2'b11);
      rd(12'h226, 8'h00);
      wr(12'h220, 8'h00);
      st(POWER_ACTIVE);
      cyc(1);
      chkGpo({opd[7], opd[5]});
      cyc(opd[2:0] * TICK - 3);
      chkGpo({opd[7], opd[5]});
      cyc(7);
      chkGpo(2'b00);
      rd(12'h226, 8'h28);
    end
    $display("test outputs done");
    pd(1, POWER_PARTIAL);
    cyc(1);
    chkGpo(2'b00);
    wr(12'h224, 8'h00);
    st(POWER_PARTIAL);
    wr(12'h388, 8'h00);
    st(POWER_ACTIVE);
    cyc(1);
    chkGpo(2'b00);
    softReset = 1'b1;
    cyc(1);
    softReset = 1'b0;
    wr(12'h227, 8'hCE);
    rd(12'h227, 8'h31);
    rd(12'h226, 8'h09);
    $display("test partial done");
    wr(12'h226, 8'h00);
    useCrystal = 1'b1;
    pd(1, POWER_PARTIAL);
    wr(12'h220, 8'h00);
    st(POWER_ACTIVE);
    pd(0, POWER_FULL);
    wr(12'h220, 8'h00);
    st(POWER_FULL);
    rst_n = 1'b0;
    cyc(1);
    rst_n = 1'b1;
    useCrystal = 1'b0;
    st(POWER_ACTIVE);
    wr(12'h227, 8'hCE);
    rd(12'h227, 8'h00);
    $display("test crystal done");
    finishTest();
  end
endmodule
